// ===== logic/pmcs_pkg.sv
// Purpose: constants of the position monitor and cam sequencer
// Assumes: apb slave with 32-bit data, byte addresses in the low 8 bits
// Notes: one aligned word per register
// Functional notes
// - setpoint not changing sets stationary flag
// - stationary and inside positioning window: target reached
// - standstill window missed before time limit: fault
// - positioning window missed before time limit: fault
// - standstill band is target plus minus window
// - positioning band is target plus minus window
// - following error setpoint minus actual, fault above tolerance
// - zero tolerance disables following error supervision
// - two independent cam outputs from two positions
// - status bit 8: actual at or below cam one
// - status bit 9: actual at or below cam two
// - jerk limit applied only while activation is one
// - profile kept within velocity, acceleration, deceleration limits
// - override scales acceleration and deceleration limits
// - controller select low activates position controller
package pmcs_pkg;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SS_WINDOW = 8'h04;
  localparam logic [7:0] OFS_SS_TIME = 8'h08;
  localparam logic [7:0] OFS_POS_WINDOW = 8'h0c;
  localparam logic [7:0] OFS_POS_TIME = 8'h10;
  localparam logic [7:0] OFS_FE_TOL = 8'h14;
  localparam logic [7:0] OFS_CAM_ONE = 8'h18;
  localparam logic [7:0] OFS_CAM_TWO = 8'h1c;
  localparam logic [7:0] OFS_VEL_LIMIT = 8'h20;
  localparam logic [7:0] OFS_ACC_LIMIT = 8'h24;
  localparam logic [7:0] OFS_DEC_LIMIT = 8'h28;
  localparam logic [7:0] OFS_JERK_LIMIT = 8'h2c;
  localparam logic [7:0] OFS_KP = 8'h30;
  localparam logic [7:0] OFS_TN = 8'h34;
  localparam logic [7:0] OFS_PRECONTROL = 8'h38;
  localparam logic [7:0] OFS_STATUS = 8'h40;
  localparam logic [7:0] OFS_DYN_FE = 8'h44;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h48;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h4c;
  localparam logic [7:0] OFS_FAULT_CODE = 8'h50;
  // control register fields
  localparam int CTRL_SELECT_BIT = 0;
  localparam int CTRL_JERK_BIT = 1;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  // status word fields
  localparam int ST_STATIONARY = 0;
  localparam int ST_TARGET = 1;
  localparam int ST_STANDSTILL = 2;
  localparam int ST_CTRL_ACTIVE = 3;
  localparam int ST_JERK_ACTIVE = 4;
  localparam int ST_CAM_ONE = 8;
  localparam int ST_CAM_TWO = 9;
  // event bits
  localparam int EV_STANDSTILL = 0;
  localparam int EV_POSITIONING = 1;
  localparam int EV_FOLLOWING = 2;
  localparam int EV_N = 3;
  localparam logic [15:0] FAULT_STANDSTILL = 16'h1d1a;
  localparam logic [15:0] FAULT_POSITIONING = 16'h1d1b;
  localparam logic [15:0] FAULT_FOLLOWING = 16'h1d1c;
  localparam logic [7:0] OVERRIDE_FULL = 8'h64;
  localparam logic [31:0] PRECONTROL_RESET = 32'h0000_0064;
endpackage

// ===== logic/pmcs_top.sv
// Purpose: position loop supervision, profile limiter and cam sequencer
// Assumes: sample_tick pulses once per position-control sampling cycle
// Notes: apb slave, no wait states, slverr on unmapped addresses
`timescale 1ns/1ps
module pmcs_top #(
  parameter int PW = 32,
  parameter int TW = 16,
  parameter int OW = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sample_tick,
  input wire logic positioning_active,
  input wire logic signed [PW-1:0] velocity_command,
  input wire logic [OW-1:0] override_pct,
  input wire logic signed [PW-1:0] actual_position,
  output logic signed [PW-1:0] position_setpoint,
  output logic signed [PW-1:0] velocity_setpoint,
  output logic [15:0] positioner_status_word,
  output logic [15:0] fault_code,
  output logic cam_one_out,
  output logic cam_two_out,
  output logic irq
);
  localparam int XW = PW + 2;
  localparam int PRW = PW + OW;
  localparam logic [31:0] CTRL_WR_MASK = (32'h0000_0001 << pmcs_pkg::CTRL_SELECT_BIT) |
                                         (32'h0000_0001 << pmcs_pkg::CTRL_JERK_BIT);

  // configuration registers
  logic [31:0] ctrl_r;
  logic [PW-1:0] standstill_window_r;
  logic [TW-1:0] standstill_time_limit_r;
  logic [PW-1:0] positioning_window_r;
  logic [TW-1:0] positioning_time_limit_r;
  logic [PW-1:0] following_error_tolerance_r;
  logic signed [PW-1:0] cam_position_one_r;
  logic signed [PW-1:0] cam_position_two_r;
  logic [PW-1:0] velocity_limit_r;
  logic [PW-1:0] acceleration_limit_r;
  logic [PW-1:0] deceleration_limit_r;
  logic [PW-1:0] jerk_limit_r;
  logic [31:0] proportional_gain_r;
  logic [31:0] integral_time_r;
  logic [31:0] speed_precontrol_factor_r;
  localparam int EV_N_W = pmcs_pkg::EV_N;
  logic [EV_N_W-1:0] irq_status_r;
  logic [EV_N_W-1:0] irq_mask_r;

  // apb handshake and output registers
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic irq_r;
  logic [15:0] fault_code_r;
  logic [15:0] status_r;
  logic signed [PW-1:0] dynamic_following_error_r;

  // profile and monitor state
  logic signed [XW-1:0] vel_r;
  logic signed [XW-1:0] acc_r;
  logic signed [PW-1:0] pos_sp_r;
  logic stationary_r;
  logic [TW-1:0] ss_cnt_r;
  logic [TW-1:0] pw_cnt_r;
  logic ss_done_r;
  logic pw_done_r;
  logic ss_fired_r;
  logic pw_fired_r;
  logic cam_one_r;
  logic cam_two_r;

  function automatic logic signed [XW-1:0] clampx(input logic signed [XW-1:0] x,
                                                  input logic signed [XW-1:0] lim);
    if (x > lim) begin
      clampx = lim;
    end else if (x < -lim) begin
      clampx = -lim;
    end else begin
      clampx = x;
    end
  endfunction

  // bus decode
  wire setup_ph = psel & ~penable;
  wire access_ph = psel & penable & pready_r;
  wire wr_en = access_ph & pwrite;
  wire hit_ctrl = (paddr == pmcs_pkg::OFS_CTRL);
  wire hit_ssw = (paddr == pmcs_pkg::OFS_SS_WINDOW);
  wire hit_sst = (paddr == pmcs_pkg::OFS_SS_TIME);
  wire hit_pww = (paddr == pmcs_pkg::OFS_POS_WINDOW);
  wire hit_pwt = (paddr == pmcs_pkg::OFS_POS_TIME);
  wire hit_fet = (paddr == pmcs_pkg::OFS_FE_TOL);
  wire hit_cam1 = (paddr == pmcs_pkg::OFS_CAM_ONE);
  wire hit_cam2 = (paddr == pmcs_pkg::OFS_CAM_TWO);
  wire hit_vel = (paddr == pmcs_pkg::OFS_VEL_LIMIT);
  wire hit_acc = (paddr == pmcs_pkg::OFS_ACC_LIMIT);
  wire hit_dec = (paddr == pmcs_pkg::OFS_DEC_LIMIT);
  wire hit_jerk = (paddr == pmcs_pkg::OFS_JERK_LIMIT);
  wire hit_kp = (paddr == pmcs_pkg::OFS_KP);
  wire hit_tn = (paddr == pmcs_pkg::OFS_TN);
  wire hit_pre = (paddr == pmcs_pkg::OFS_PRECONTROL);
  wire hit_stat = (paddr == pmcs_pkg::OFS_STATUS);
  wire hit_dfe = (paddr == pmcs_pkg::OFS_DYN_FE);
  wire hit_ist = (paddr == pmcs_pkg::OFS_IRQ_STATUS);
  wire hit_imk = (paddr == pmcs_pkg::OFS_IRQ_MASK);
  wire hit_fc = (paddr == pmcs_pkg::OFS_FAULT_CODE);
  wire hit_any = hit_ctrl | hit_ssw | hit_sst | hit_pww | hit_pwt | hit_fet | hit_cam1 | hit_cam2 |
                 hit_vel | hit_acc | hit_dec | hit_jerk | hit_kp | hit_tn | hit_pre | hit_stat |
                 hit_dfe | hit_ist | hit_imk | hit_fc;

  wire [31:0] rd_data =
    hit_ctrl ? ctrl_r :
    hit_ssw ? 32'(standstill_window_r) :
    hit_sst ? 32'(standstill_time_limit_r) :
    hit_pww ? 32'(positioning_window_r) :
    hit_pwt ? 32'(positioning_time_limit_r) :
    hit_fet ? 32'(following_error_tolerance_r) :
    hit_cam1 ? 32'(cam_position_one_r) :
    hit_cam2 ? 32'(cam_position_two_r) :
    hit_vel ? 32'(velocity_limit_r) :
    hit_acc ? 32'(acceleration_limit_r) :
    hit_dec ? 32'(deceleration_limit_r) :
    hit_jerk ? 32'(jerk_limit_r) :
    hit_kp ? proportional_gain_r :
    hit_tn ? integral_time_r :
    hit_pre ? speed_precontrol_factor_r :
    hit_stat ? {16'h0000, status_r} :
    hit_dfe ? 32'(dynamic_following_error_r) :
    hit_ist ? 32'(irq_status_r) :
    hit_imk ? 32'(irq_mask_r) :
    hit_fc ? {16'h0000, fault_code_r} : 32'h0000_0000;

  // controller enable and jerk activation
  wire ctrl_active = ~ctrl_r[pmcs_pkg::CTRL_SELECT_BIT];
  wire jerk_on = ctrl_r[pmcs_pkg::CTRL_JERK_BIT];

  // override scaled limits
  wire [PRW-1:0] acc_prod = PRW'(acceleration_limit_r) * PRW'(override_pct);
  wire [PRW-1:0] dec_prod = PRW'(deceleration_limit_r) * PRW'(override_pct);
  wire [PRW-1:0] ovr_full = PRW'(pmcs_pkg::OVERRIDE_FULL);
  wire [PRW-1:0] acc_scaled = acc_prod / ovr_full;
  wire [PRW-1:0] dec_scaled = dec_prod / ovr_full;
  wire signed [XW-1:0] acc_eff = $signed({2'b00, acc_scaled[PW-1:0]});
  wire signed [XW-1:0] dec_eff = $signed({2'b00, dec_scaled[PW-1:0]});
  wire signed [XW-1:0] vlim = $signed({2'b00, velocity_limit_r});
  wire signed [XW-1:0] jlim = $signed({2'b00, jerk_limit_r});

  // profile generator
  wire signed [XW-1:0] v_cmd = XW'(velocity_command);
  wire run_profile = positioning_active & ctrl_active;
  wire signed [XW-1:0] v_tgt = run_profile ? clampx(v_cmd, vlim) : '0;
  wire signed [XW-1:0] dv = v_tgt - vel_r;
  wire dv_up = (dv > 0) && (vel_r >= 0);
  wire dv_down = (dv < 0) && (vel_r <= 0);
  wire speeding_up = dv_up || dv_down;
  wire signed [XW-1:0] step_lim = speeding_up ? acc_eff : dec_eff;
  wire signed [XW-1:0] a_goal = clampx(dv, step_lim);
  wire signed [XW-1:0] a_jerk = acc_r + clampx(a_goal - acc_r, jlim);
  wire over_up = (dv >= 0) && (a_jerk > dv);
  wire over_down = (dv <= 0) && (a_jerk < dv);
  wire jerk_over = over_up || over_down;
  wire signed [XW-1:0] a_use = jerk_on ? (jerk_over ? dv : a_jerk) : a_goal;
  wire signed [XW-1:0] v_nxt = ctrl_active ? clampx(vel_r + a_use, vlim) : '0;
  wire signed [PW-1:0] pos_sp_nxt = ctrl_active ? (pos_sp_r + vel_r[PW-1:0]) : actual_position;

  // supervision on the sampled values
  wire stationary = run_profile & (vel_r == '0);
  wire signed [XW-1:0] err = XW'(pos_sp_r) - XW'(actual_position);
  wire signed [XW-1:0] abs_err = (err < 0) ? -err : err;
  // window bands around the target
  wire signed [XW-1:0] ss_band = $signed({2'b00, standstill_window_r});
  wire signed [XW-1:0] pos_band = $signed({2'b00, positioning_window_r});
  wire in_ss_win = abs_err <= ss_band;
  wire in_pos_win = abs_err <= pos_band;
  wire ss_running = stationary & stationary_r & ~ss_done_r & ~ss_fired_r;
  wire pw_running = stationary & stationary_r & ~pw_done_r & ~pw_fired_r;
  wire ss_ev = sample_tick & ss_running & ~in_ss_win & (ss_cnt_r >= standstill_time_limit_r);
  wire pw_ev = sample_tick & pw_running & ~in_pos_win & (pw_cnt_r >= positioning_time_limit_r);
  wire fe_on = (following_error_tolerance_r != '0);
  wire fe_ev = sample_tick & ctrl_active & positioning_active & fe_on &
               (abs_err > $signed({2'b00, following_error_tolerance_r}));
  wire target_reached = stationary & in_pos_win;
  wire cam_one = actual_position <= cam_position_one_r;
  wire cam_two = actual_position <= cam_position_two_r;

  wire [15:0] status_nxt = (16'h0001 << pmcs_pkg::ST_STATIONARY) & {16{stationary}} |
                           (16'h0001 << pmcs_pkg::ST_TARGET) & {16{target_reached}} |
                           (16'h0001 << pmcs_pkg::ST_STANDSTILL) & {16{stationary & in_ss_win}} |
                           (16'h0001 << pmcs_pkg::ST_CTRL_ACTIVE) & {16{ctrl_active}} |
                           (16'h0001 << pmcs_pkg::ST_JERK_ACTIVE) & {16{jerk_on}} |
                           (16'h0001 << pmcs_pkg::ST_CAM_ONE) & {16{cam_one}} |
                           (16'h0001 << pmcs_pkg::ST_CAM_TWO) & {16{cam_two}};

  // sticky events, set wins over write-one-to-clear
  wire [EV_N_W-1:0] events = {fe_ev, pw_ev, ss_ev};
  wire ist_wr = wr_en & hit_ist;
  wire [EV_N_W-1:0] clr_mask = ist_wr ? pwdata[EV_N_W-1:0] : '0;
  wire [EV_N_W-1:0] irq_status_nxt = (irq_status_r & ~clr_mask) | events;
  wire [15:0] fault_code_nxt = fe_ev ? pmcs_pkg::FAULT_FOLLOWING :
                               pw_ev ? pmcs_pkg::FAULT_POSITIONING :
                               ss_ev ? pmcs_pkg::FAULT_STANDSTILL : fault_code_r;

  // apb response
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end else begin
      pready_r <= setup_ph;
      pslverr_r <= setup_ph & ~hit_any;
      prdata_r <= (setup_ph & ~pwrite) ? rd_data : prdata_r;
    end
  end

  // software written configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= pmcs_pkg::CTRL_RESET;
      standstill_window_r <= '0;
      standstill_time_limit_r <= '0;
      positioning_window_r <= '0;
      positioning_time_limit_r <= '0;
      following_error_tolerance_r <= '0;
      cam_position_one_r <= '0;
      cam_position_two_r <= '0;
      velocity_limit_r <= '0;
      acceleration_limit_r <= '0;
      deceleration_limit_r <= '0;
      jerk_limit_r <= '0;
      proportional_gain_r <= '0;
      integral_time_r <= '0;
      speed_precontrol_factor_r <= pmcs_pkg::PRECONTROL_RESET;
      irq_mask_r <= '0;
    end else if (wr_en) begin
      if (hit_ctrl) ctrl_r <= pwdata & CTRL_WR_MASK;
      if (hit_ssw) standstill_window_r <= pwdata[PW-1:0];
      if (hit_sst) standstill_time_limit_r <= pwdata[TW-1:0];
      if (hit_pww) positioning_window_r <= pwdata[PW-1:0];
      if (hit_pwt) positioning_time_limit_r <= pwdata[TW-1:0];
      if (hit_fet) following_error_tolerance_r <= pwdata[PW-1:0];
      if (hit_cam1) cam_position_one_r <= pwdata[PW-1:0];
      if (hit_cam2) cam_position_two_r <= pwdata[PW-1:0];
      if (hit_vel) velocity_limit_r <= pwdata[PW-1:0];
      if (hit_acc) acceleration_limit_r <= pwdata[PW-1:0];
      if (hit_dec) deceleration_limit_r <= pwdata[PW-1:0];
      if (hit_jerk) jerk_limit_r <= pwdata[PW-1:0];
      if (hit_kp) proportional_gain_r <= pwdata;
      if (hit_tn) integral_time_r <= pwdata;
      if (hit_pre) speed_precontrol_factor_r <= pwdata;
      if (hit_imk) irq_mask_r <= pwdata[EV_N_W-1:0];
    end
  end

  // interrupt state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_r <= '0;
      fault_code_r <= '0;
      irq_r <= 1'b0;
    end else begin
      irq_status_r <= irq_status_nxt;
      fault_code_r <= fault_code_nxt;
      irq_r <= |(irq_status_nxt & irq_mask_r);
    end
  end

  // profile state, one step per sample
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vel_r <= '0;
      acc_r <= '0;
      pos_sp_r <= '0;
    end else if (sample_tick) begin
      vel_r <= v_nxt;
      acc_r <= ctrl_active ? a_use : '0;
      pos_sp_r <= pos_sp_nxt;
    end
  end

  // window timers, restarted on each new stationary phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stationary_r <= 1'b0;
      ss_cnt_r <= '0;
      pw_cnt_r <= '0;
      ss_done_r <= 1'b0;
      pw_done_r <= 1'b0;
      ss_fired_r <= 1'b0;
      pw_fired_r <= 1'b0;
    end else if (sample_tick) begin
      stationary_r <= stationary;
      if (!(stationary & stationary_r)) begin
        ss_cnt_r <= '0;
        pw_cnt_r <= '0;
        ss_done_r <= 1'b0;
        pw_done_r <= 1'b0;
        ss_fired_r <= 1'b0;
        pw_fired_r <= 1'b0;
      end else begin
        ss_cnt_r <= ss_running ? ss_cnt_r + 1'b1 : ss_cnt_r;
        pw_cnt_r <= pw_running ? pw_cnt_r + 1'b1 : pw_cnt_r;
        ss_done_r <= ss_done_r | (in_ss_win & ~ss_fired_r);
        pw_done_r <= pw_done_r | (in_pos_win & ~pw_fired_r);
        ss_fired_r <= ss_fired_r | ss_ev;
        pw_fired_r <= pw_fired_r | pw_ev;
      end
    end
  end

  // sampled status outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= '0;
      dynamic_following_error_r <= '0;
      cam_one_r <= 1'b0;
      cam_two_r <= 1'b0;
    end else if (sample_tick) begin
      status_r <= status_nxt;
      dynamic_following_error_r <= err[PW-1:0];
      cam_one_r <= cam_one;
      cam_two_r <= cam_two;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign position_setpoint = pos_sp_r;
  assign velocity_setpoint = vel_r[PW-1:0];
  assign positioner_status_word = status_r;
  assign fault_code = fault_code_r;
  assign cam_one_out = cam_one_r;
  assign cam_two_out = cam_two_r;
  assign irq = irq_r;
endmodule

// ===== sim/pmcs_axis_model.sv
// Purpose: motor axis with encoder, moves once per sample tick
// Assumes: follow mode chases setpoint plus offset at a bounded rate
// Notes: direct mode jumps to a commanded position
`timescale 1ns/1ps
module pmcs_axis_model #(
  parameter int PW = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sample_tick,
  input wire logic follow,
  input wire logic signed [PW-1:0] pos_cmd,
  input wire logic signed [PW-1:0] offset,
  input wire logic signed [PW-1:0] rate,
  input wire logic signed [PW-1:0] position_setpoint,
  output logic signed [PW-1:0] actual_position
);
  logic signed [PW-1:0] act_r;
  logic signed [PW-1:0] goal;
  logic signed [PW-1:0] diff;
  assign goal = follow ? position_setpoint + offset : pos_cmd;
  assign diff = goal - act_r;
  assign actual_position = act_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_r <= '0;
    end else if (sample_tick) begin
      act_r <= !follow ? goal : diff > rate ? act_r + rate : diff < -rate ? act_r - rate : goal;
    end
  end
endmodule

// ===== sim/pmcs_top_props.sv
// Purpose: port level checks of the supervision block
// Assumes: status, setpoints and faults move only on sample ticks
// Notes: bound into pmcs_top after the module
`timescale 1ns/1ps
module pmcs_top_props #(
  parameter int PW = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sample_tick,
  input wire logic positioning_active,
  input wire logic signed [PW-1:0] position_setpoint,
  input wire logic signed [PW-1:0] velocity_setpoint,
  input wire logic [15:0] positioner_status_word,
  input wire logic [15:0] fault_code,
  input wire logic cam_one_out,
  input wire logic cam_two_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_CAM_ONE: assert property (cam_one_out == positioner_status_word[8])
    else $error("cam one output differs from status bit");
  AST_CAM_TWO: assert property (cam_two_out == positioner_status_word[9])
    else $error("cam two output differs from status bit");
  AST_STATUS_HOLD: assert property (!sample_tick |=> $stable(positioner_status_word))
    else $error("status moved without a tick");
  AST_SETPOINT_HOLD: assert property (!sample_tick |=> $stable(position_setpoint) &&
    $stable(velocity_setpoint)) else $error("setpoints moved without a tick");
  AST_TARGET_STAT: assert property (positioner_status_word[1] |-> positioner_status_word[0])
    else $error("target reached while setpoint not stationary");
  AST_STANDSTILL_STAT: assert property (positioner_status_word[2] |-> positioner_status_word[0])
    else $error("standstill flag while setpoint not stationary");
  AST_STAT_IDLE: assert property (sample_tick && !positioning_active |=> !positioner_status_word[0])
    else $error("stationary flag outside positioning");
  AST_FAULT_LEGAL: assert property ($changed(fault_code) |-> fault_code == pmcs_pkg::FAULT_STANDSTILL ||
    fault_code == pmcs_pkg::FAULT_POSITIONING || fault_code == pmcs_pkg::FAULT_FOLLOWING)
    else $error("unknown fault code raised");
  AST_FAULT_ON_TICK: assert property ($changed(fault_code) |-> $past(sample_tick))
    else $error("fault code changed off a tick");
  AST_BRAKE_HOLD: assert property (sample_tick && !positioning_active && velocity_setpoint == 0
    |=> velocity_setpoint == 0) else $error("velocity left zero while idle");
endmodule
bind pmcs_top pmcs_top_props #(.PW(PW)) u_props (.pclk(pclk), .presetn(presetn), .sample_tick(sample_tick),
  .positioning_active(positioning_active), .position_setpoint(position_setpoint),
  .velocity_setpoint(velocity_setpoint), .positioner_status_word(positioner_status_word),
  .fault_code(fault_code), .cam_one_out(cam_one_out), .cam_two_out(cam_two_out));

// ===== sim/pmcs_top_tb.sv
// Purpose: self-checking bench of the supervision block
// Assumes: ticks every fourth clock, apb master tasks
// Notes: axis model closes the loop
`timescale 1ns/1ps
module pmcs_top_tb;
  logic pclk, presetn, psel, penable, pwrite, sample_tick, positioning_active, follow;
  logic pready, pslverr, erv, cam_one_out, cam_two_out, irq;
  logic [7:0] paddr, override_pct;
  logic [31:0] pwdata, prdata, rdv;
  logic signed [31:0] velocity_command, actual_position, position_setpoint, velocity_setpoint, pos_cmd, offset, rate;
  logic [15:0] positioner_status_word, fault_code;
  logic [1:0] tcnt;
  int n_errors = 0;
  int n_tests = 0;
  pmcs_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample_tick(sample_tick),
    .positioning_active(positioning_active), .velocity_command(velocity_command), .override_pct(override_pct),
    .actual_position(actual_position), .position_setpoint(position_setpoint), .velocity_setpoint(velocity_setpoint),
    .positioner_status_word(positioner_status_word), .fault_code(fault_code), .cam_one_out(cam_one_out),
    .cam_two_out(cam_two_out), .irq(irq));
  pmcs_axis_model u_axis (.pclk(pclk), .presetn(presetn), .sample_tick(sample_tick), .follow(follow),
    .pos_cmd(pos_cmd), .offset(offset), .rate(rate), .position_setpoint(position_setpoint),
    .actual_position(actual_position));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    tcnt <= tcnt + 2'h1;
    sample_tick <= (tcnt == 2'h2);
  end
  task final_report;
    if (n_errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wt(input int n);
    repeat (n) @(posedge pclk iff sample_tick === 1'b1);
    @(posedge pclk);
  endtask
  task t_regs;
    apb(1'b0, pmcs_pkg::OFS_CTRL, 32'h0);
    chk("ctrl reset", rdv, pmcs_pkg::CTRL_RESET);
    apb(1'b0, pmcs_pkg::OFS_PRECONTROL, 32'h0);
    chk("precontrol reset", rdv, pmcs_pkg::PRECONTROL_RESET);
    apb(1'b0, 8'h3c, 32'h0);
    chk("unmapped error", {31'h0, erv}, 32'h1);
    apb(1'b1, pmcs_pkg::OFS_TN, 32'h7);
    apb(1'b0, pmcs_pkg::OFS_TN, 32'h0);
    chk("integral time", rdv, 32'h7);
    apb(1'b1, pmcs_pkg::OFS_TN, 32'h0);
    apb(1'b1, pmcs_pkg::OFS_PRECONTROL, pmcs_pkg::PRECONTROL_RESET);
    apb(1'b1, pmcs_pkg::OFS_SS_WINDOW, 32'h14);
    apb(1'b1, pmcs_pkg::OFS_SS_TIME, 32'h3);
    apb(1'b1, pmcs_pkg::OFS_POS_WINDOW, 32'h5);
    apb(1'b1, pmcs_pkg::OFS_POS_TIME, 32'h6);
    apb(1'b1, pmcs_pkg::OFS_CAM_ONE, 32'h64);
    apb(1'b1, pmcs_pkg::OFS_CAM_TWO, 32'hc8);
    apb(1'b1, pmcs_pkg::OFS_VEL_LIMIT, 32'ha);
    apb(1'b1, pmcs_pkg::OFS_ACC_LIMIT, 32'h3);
    apb(1'b1, pmcs_pkg::OFS_DEC_LIMIT, 32'h4);
    apb(1'b1, pmcs_pkg::OFS_JERK_LIMIT, 32'h1);
    apb(1'b1, pmcs_pkg::OFS_FE_TOL, 32'h0);
  endtask
  task t_cams;
    int v [6] = '{99, 100, 101, 150, 200, 201};
    foreach (v[i]) begin
      pos_cmd <= v[i];
      wt(2);
      chk("cam one", {31'h0, cam_one_out}, {31'h0, v[i] <= 100});
      chk("cam two", {31'h0, positioner_status_word[9]}, {31'h0, v[i] <= 200});
      chk("cams independent", {31'h0, positioner_status_word[8]}, {31'h0, v[i] <= 100});
      chk("cam two out", {31'h0, cam_two_out}, {31'h0, v[i] <= 200});
      chk("setpoint tracks", position_setpoint, v[i]);
    end
    chk("controller off", {31'h0, positioner_status_word[3]}, 32'h0);
    apb(1'b1, pmcs_pkg::OFS_CTRL, 32'h0);
    follow <= 1'b1;
    wt(1);
    chk("controller on", {31'h0, positioner_status_word[3]}, 32'h1);
  endtask
  task mon(input int offs, input logic tgt, input logic [31:0] ev, input logic [15:0] fc);
    apb(1'b1, pmcs_pkg::OFS_IRQ_STATUS, 32'h7);
    offset <= offs;
    positioning_active <= 1'b1;
    wt(10);
    chk("stationary", {31'h0, positioner_status_word[0]}, 32'h1);
    chk("target", {31'h0, positioner_status_word[1]}, {31'h0, tgt});
    apb(1'b0, pmcs_pkg::OFS_IRQ_STATUS, 32'h0);
    chk("events", rdv, ev);
    chk("fault code", {16'h0, fault_code}, {16'h0, fc});
    positioning_active <= 1'b0;
    wt(2);
  endtask
  task t_irq;
    apb(1'b1, pmcs_pkg::OFS_IRQ_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq unmasked", {31'h0, irq}, 32'h1);
    apb(1'b1, pmcs_pkg::OFS_IRQ_MASK, 32'h2);
    repeat (2) @(posedge pclk);
    chk("irq masked", {31'h0, irq}, 32'h0);
    apb(1'b1, pmcs_pkg::OFS_IRQ_MASK, 32'h1);
    apb(1'b1, pmcs_pkg::OFS_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
  endtask
  task prof(input logic [7:0] ovr, input logic jerk, input int up1, input int dn1);
    apb(1'b1, pmcs_pkg::OFS_CTRL, {30'h0, jerk, 1'b0});
    override_pct <= ovr;
    velocity_command <= 1000;
    positioning_active <= 1'b1;
    wt(1);
    chk("first rise", velocity_setpoint, up1);
    chk("jerk active", {31'h0, positioner_status_word[4]}, {31'h0, jerk});
    wt(12);
    chk("velocity clamp", velocity_setpoint, 32'ha);
    positioning_active <= 1'b0;
    wt(1);
    chk("first fall", velocity_setpoint, 10 - dn1);
    wt(12);
    chk("braked", velocity_setpoint, 32'h0);
  endtask
  task t_follow;
    apb(1'b1, pmcs_pkg::OFS_FE_TOL, 32'h5);
    apb(1'b1, pmcs_pkg::OFS_IRQ_STATUS, 32'h7);
    rate <= 1;
    offset <= 0;
    velocity_command <= 8;
    positioning_active <= 1'b1;
    wt(10);
    chk("following fault", {16'h0, fault_code}, {16'h0, pmcs_pkg::FAULT_FOLLOWING});
    apb(1'b0, pmcs_pkg::OFS_DYN_FE, 32'h0);
    chk("error over tolerance", {31'h0, $signed(rdv) > 5}, 32'h1);
    apb(1'b0, pmcs_pkg::OFS_IRQ_STATUS, 32'h0);
    chk("following event", rdv & 32'h4, 32'h4);
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata, tcnt, sample_tick, positioning_active, follow} = '0;
    {velocity_command, pos_cmd, offset} = '0;
    override_pct = pmcs_pkg::OVERRIDE_FULL;
    rate = 1000;
    presetn = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_cams;
    mon(3, 1'b1, 32'h0, 16'h0);
    mon(-5, 1'b1, 32'h0, 16'h0);
    mon(20, 1'b0, 32'h2, pmcs_pkg::FAULT_POSITIONING);
    mon(21, 1'b0, 32'h3, pmcs_pkg::FAULT_POSITIONING);
    apb(1'b1, pmcs_pkg::OFS_POS_TIME, 32'h64);
    mon(21, 1'b0, 32'h1, pmcs_pkg::FAULT_STANDSTILL);
    t_irq;
    prof(8'h64, 1'b0, 3, 4);
    prof(8'h32, 1'b0, 1, 2);
    prof(8'h64, 1'b1, 1, 1);
    t_follow;
    final_report;
  end
  initial begin
    #100000;
    n_errors++;
    final_report;
  end
endmodule
